// >>> verilog/eut_cfg.svh
// Purpose: Constants of the eight-bit up-count timer.
// Assumes: AXI4-Lite, 32-bit data, byte addresses.
// Notes: Offsets are word aligned.
`ifndef EUT_CFG_SVH
`define EUT_CFG_SVH

`define EUT_OFF_CTRL 8'h00
`define EUT_OFF_COUNT 8'h04
`define EUT_OFF_STATUS 8'h08
`define EUT_OFF_MASK 8'h0C
`define EUT_OFF_GLOBAL 8'h10
`define EUT_OFF_PSC 8'h14

`define EUT_BIT_RUN 0
`define EUT_BIT_SRC 1
`define EUT_BIT_LOWSPD 2
`define EUT_BIT_EDGE 3
`define EUT_BIT_ASSIGN 4
`define EUT_RATE_LSB 5
`define EUT_RATE_MSB 7
`define EUT_BIT_OVF 0
`define EUT_BIT_GIE 0

`define EUT_CTRL_RST 8'h10
`define EUT_COUNT_RST 8'h00
`define EUT_COUNT_MAX 8'hFF

`define EUT_RESP_OKAY 2'h0
`define EUT_RESP_SLVERR 2'h2

`endif

// >>> verilog/eut_pkg.sv
// Purpose: Types of the eight-bit up-count timer.
// Assumes: Used with eut_cfg.svh.
// Notes: Clock source selection is the only enumeration.
package eut_pkg;

   typedef enum logic [1:0] {
      EUT_SRC_INSTR = 2'b00,
      EUT_SRC_PIN = 2'b01,
      EUT_SRC_LOW = 2'b10
   } eut_src_type;

   typedef logic [2:0] eut_rate_type;

endpackage : eut_pkg

// >>> verilog/eut_tick_if.sv
// Purpose: Tick path from source selector through prescaler.
// Assumes: Single clock domain.
// Notes: Top drives the control fields directly.
`timescale 1ns/100ps
interface eut_tick_if;
   import eut_pkg::*;
   logic src_tick;
   logic out_tick;
   logic assign_wdt;
   logic clear;
   eut_rate_type rate;
   logic [7:0] psc_count;

   modport src (output src_tick);
   modport psc (input src_tick, input assign_wdt, input clear,
      input rate, output out_tick, output psc_count);
endinterface : eut_tick_if

// >>> verilog/eut_src_sel.sv
// Purpose: Picks the timer clock source and detects its active edge.
// Assumes: Pin and low-speed inputs are synchronous to aclk.
// Notes: Instruction clock gives a tick every cycle.
`timescale 1ns/100ps
module eut_src_sel
   import eut_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic source_select,
   input wire logic low_speed_select,
   input wire logic edge_select,
   input wire logic ext_count_clock_pin,
   input wire logic low_osc_clk,
   eut_tick_if.src tick
);
   eut_src_type src;
   logic level;
   logic prev_q;

   always_comb begin
      if (!source_select) begin
         src = EUT_SRC_INSTR;
      end else if (!low_speed_select) begin
         src = EUT_SRC_PIN;
      end else begin
         src = EUT_SRC_LOW;
      end
   end

   assign level = (src == EUT_SRC_LOW) ? low_osc_clk : ext_count_clock_pin;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= level;
      end
   end

   always_comb begin
      if (src == EUT_SRC_INSTR) begin
         tick.src_tick = 1'b1;
      end else if (edge_select) begin
         tick.src_tick = prev_q & ~level;
      end else begin
         tick.src_tick = ~prev_q & level;
      end
   end

endmodule : eut_src_sel

// >>> verilog/eut_prescaler.sv
// Purpose: Power-of-two prescaler between source and counter.
// Assumes: Watchdog use of the prescaler lives elsewhere.
// Notes: Holds its count while assigned away.
`timescale 1ns/100ps
module eut_prescaler
   import eut_pkg::*;
#(
   parameter int WIDTH = 8
)
(
   input wire logic aclk,
   input wire logic aresetn,
   eut_tick_if.psc tick
);
   logic [WIDTH-1:0] cnt_q;
   logic [WIDTH-1:0] mask;

   function automatic logic [WIDTH-1:0] rate_mask(input eut_rate_type r);
      rate_mask = {WIDTH{1'b1}} >> (WIDTH - 1 - int'(r));
   endfunction : rate_mask

   assign mask = rate_mask(tick.rate);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= '0;
      end else if (tick.clear) begin
         cnt_q <= '0;
      end else if (tick.src_tick && !tick.assign_wdt) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   always_comb begin
      if (tick.assign_wdt) begin
         tick.out_tick = tick.src_tick;
      end else begin
         tick.out_tick = tick.src_tick && !tick.clear &&
            ((cnt_q & mask) == mask);
      end
   end

   assign tick.psc_count = 8'(cnt_q);

endmodule : eut_prescaler

// >>> verilog/eut_timer.sv
// Purpose: Eight-bit up-count timer with prescaler and overflow irq.
// Assumes: AXI4-Lite slave, 32-bit data, aclk at 100 MHz.
// Notes: One write and one read in flight at most.
// Notes on behaviour
// - 8-bit counter counts qualified ticks when enabled
// - Writes load the count; reads return it
// - Source 0 selects instruction clock
// - Source 1 selects pin or low-speed clock
// - Edge select 1 falling, 0 rising
// - Assign 0 routes ticks through prescaler
// - Writing assign 0 clears the prescaler
// - Rate field gives one-in-two to one-in-256
// - Overflow sets the overflow flag
// - Irq when flag, enable and global enable set
// - Flag holds until software writes zero
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "eut_cfg.svh"
module eut_timer
   import eut_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic ext_count_clock_pin,
   input wire logic low_osc_clk,
   output logic irq
);
   // Bus state
   logic awready_q;
   logic wready_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic arready_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic aw_full_q;
   logic w_full_q;
   logic [ADDR_W-1:0] waddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;

   logic aw_take;
   logic w_take;
   logic ar_take;
   logic wr_fire;
   logic aw_full_d;
   logic w_full_d;
   logic bvalid_d;
   logic rvalid_d;

   // Block state
   logic [7:0] ctrl_q;
   logic [7:0] count_q;
   logic overflow_flag_q;
   logic overflow_irq_enable_q;
   logic global_irq_enable_q;
   logic irq_q;

   logic wr_ctrl;
   logic wr_count;
   logic wr_status;
   logic wr_mask;
   logic wr_global;
   logic wr_hit;
   logic [7:0] ctrl_new;
   logic count_tick;
   logic ovf_evt;
   logic [31:0] rd_word;
   logic rd_hit;

   eut_tick_if tick_if ();

   // Low byte merge under strobe; upper lanes hold no storage
   function automatic logic [7:0] lane0(input logic [7:0] old,
      input logic [31:0] data, input logic [3:0] strb);
      lane0 = strb[0] ? data[7:0] : old;
   endfunction : lane0

   function automatic logic addr_is(input logic [ADDR_W-1:0] a,
      input logic [7:0] off);
      addr_is = (a == ADDR_W'(off));
   endfunction : addr_is

   assign aw_take = s_axi_awvalid && awready_q;
   assign w_take = s_axi_wvalid && wready_q;
   assign ar_take = s_axi_arvalid && arready_q;
   assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
   assign aw_full_d = (aw_full_q || aw_take) && !wr_fire;
   assign w_full_d = (w_full_q || w_take) && !wr_fire;
   assign bvalid_d = wr_fire || (bvalid_q && !s_axi_bready);
   assign rvalid_d = ar_take || (rvalid_q && !s_axi_rready);

   // Write address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
      end else begin
         aw_full_q <= aw_full_d;
         w_full_q <= w_full_d;
         awready_q <= !aw_full_d && !bvalid_d;
         wready_q <= !w_full_d && !bvalid_d;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         waddr_q <= '0;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
      end else begin
         if (aw_take) begin
            waddr_q <= s_axi_awaddr;
         end
         if (w_take) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
      end
   end

   // Write decode
   always_comb begin
      wr_ctrl = 1'b0;
      wr_count = 1'b0;
      wr_status = 1'b0;
      wr_mask = 1'b0;
      wr_global = 1'b0;
      wr_hit = 1'b1;
      if (addr_is(waddr_q, `EUT_OFF_CTRL)) begin
         wr_ctrl = wr_fire;
      end else if (addr_is(waddr_q, `EUT_OFF_COUNT)) begin
         wr_count = wr_fire;
      end else if (addr_is(waddr_q, `EUT_OFF_STATUS)) begin
         wr_status = wr_fire;
      end else if (addr_is(waddr_q, `EUT_OFF_MASK)) begin
         wr_mask = wr_fire;
      end else if (addr_is(waddr_q, `EUT_OFF_GLOBAL)) begin
         wr_global = wr_fire;
      end else if (addr_is(waddr_q, `EUT_OFF_PSC)) begin
         wr_hit = 1'b1;
      end else begin
         wr_hit = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q <= `EUT_RESP_OKAY;
      end else begin
         bvalid_q <= bvalid_d;
         if (wr_fire) begin
            bresp_q <= wr_hit ? `EUT_RESP_OKAY : `EUT_RESP_SLVERR;
         end
      end
   end

   // Read side: answer one cycle after the address is taken
   always_comb begin
      rd_word = 32'h00000000;
      rd_hit = 1'b1;
      if (addr_is(s_axi_araddr, `EUT_OFF_CTRL)) begin
         rd_word[7:0] = ctrl_q;
      end else if (addr_is(s_axi_araddr, `EUT_OFF_COUNT)) begin
         rd_word[7:0] = count_q;
      end else if (addr_is(s_axi_araddr, `EUT_OFF_STATUS)) begin
         rd_word[`EUT_BIT_OVF] = overflow_flag_q;
      end else if (addr_is(s_axi_araddr, `EUT_OFF_MASK)) begin
         rd_word[`EUT_BIT_OVF] = overflow_irq_enable_q;
      end else if (addr_is(s_axi_araddr, `EUT_OFF_GLOBAL)) begin
         rd_word[`EUT_BIT_GIE] = global_irq_enable_q;
      end else if (addr_is(s_axi_araddr, `EUT_OFF_PSC)) begin
         rd_word[7:0] = tick_if.psc_count;
      end else begin
         rd_hit = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= `EUT_RESP_OKAY;
      end else begin
         arready_q <= !rvalid_d;
         rvalid_q <= rvalid_d;
         if (ar_take) begin
            rdata_q <= rd_word;
            rresp_q <= rd_hit ? `EUT_RESP_OKAY : `EUT_RESP_SLVERR;
         end
      end
   end

   // Control register
   assign ctrl_new = lane0(ctrl_q, wdata_q, wstrb_q);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= `EUT_CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_q <= ctrl_new;
      end
   end

   // Tick path
   eut_src_sel u_src (
      .aclk(aclk),
      .aresetn(aresetn),
      .source_select(ctrl_q[`EUT_BIT_SRC]),
      .low_speed_select(ctrl_q[`EUT_BIT_LOWSPD]),
      .edge_select(ctrl_q[`EUT_BIT_EDGE]),
      .ext_count_clock_pin(ext_count_clock_pin),
      .low_osc_clk(low_osc_clk),
      .tick(tick_if.src)
   );

   assign tick_if.assign_wdt = ctrl_q[`EUT_BIT_ASSIGN];
   assign tick_if.rate = ctrl_q[`EUT_RATE_MSB:`EUT_RATE_LSB];
   // clear when a write puts zero in assign
   assign tick_if.clear = wr_ctrl && wstrb_q[0] &&
      !wdata_q[`EUT_BIT_ASSIGN];

   eut_prescaler #(
      .WIDTH(8)
   ) u_psc (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(tick_if.psc)
   );

   assign count_tick = ctrl_q[`EUT_BIT_RUN] && tick_if.out_tick;
   // wrap from all-ones; a load in the same cycle wins
   assign ovf_evt = count_tick && !wr_count && (count_q == `EUT_COUNT_MAX);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_q <= `EUT_COUNT_RST;
      end else if (wr_count) begin
         count_q <= lane0(count_q, wdata_q, wstrb_q);
      end else if (count_tick) begin
         count_q <= count_q + 8'h01;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         overflow_flag_q <= 1'b0;
      end else if (ovf_evt) begin
         overflow_flag_q <= 1'b1;
      end else if (wr_status && wstrb_q[0] && !wdata_q[`EUT_BIT_OVF]) begin
         overflow_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         overflow_irq_enable_q <= 1'b0;
         global_irq_enable_q <= 1'b0;
      end else begin
         if (wr_mask && wstrb_q[0]) begin
            overflow_irq_enable_q <= wdata_q[`EUT_BIT_OVF];
         end
         if (wr_global && wstrb_q[0]) begin
            global_irq_enable_q <= wdata_q[`EUT_BIT_GIE];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= overflow_flag_q && overflow_irq_enable_q &&
            global_irq_enable_q;
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign irq = irq_q;

endmodule : eut_timer

// >>> test/eut_timer_monitor.sv
// Purpose: Port-level checks of the up-count timer.
// Assumes: Bound into eut_timer; single aclk domain.
// Notes: Irq relations lean on bus timing, the flag is not visible.
`timescale 1ns/100ps
module eut_timer_monitor (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic irq
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   chk_b_after_both: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write response not two cycles after request");
   chk_b_holds: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   chk_r_next: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   chk_r_holds: assert property (
      s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read data dropped early");
   chk_upper_zero: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("upper read bits set");
   chk_aw_refused: assert property (
      s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("second write address accepted");
   chk_w_refused: assert property (
      s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
      else $error("second write data accepted");
   chk_ar_busy: assert property (
      s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while data pending");
   chk_irq_clear: assert property (
      $fell(irq) |-> $past(s_axi_bvalid))
      else $error("irq fell without a write");
endmodule : eut_timer_monitor

bind eut_timer eut_timer_monitor i_eut_timer_monitor (
   .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
   .s_axi_rvalid, .s_axi_rready, .irq
);

// >>> test/tb_top.sv
// Purpose: Self-checking bench of the up-count timer.
// Assumes: Pin and oscillator inputs move on aclk edges.
// Notes: Pin source keeps counts exact; instruction clock timed by bus.
`timescale 1ns/100ps
`include "eut_cfg.svh"
module tb_top;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic ext_count_clock_pin = 1'b0, low_osc_clk = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, irq;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   logic [31:0] w;
   int mismatches = 0;
   int checked = 0;
   int cycles = 0;

   eut_timer i_eut_timer (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .ext_count_clock_pin, .low_osc_clk,
      .irq
   );

   initial begin
      forever #5 aclk = ~aclk;
   end

   task automatic chk(input string n, input logic [33:0] s, e);
      checked++;
      if (s !== e) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   task tally_and_finish;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : tally_and_finish

   // Ready is held back one cycle so the slave must keep its answer
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r = 2'h0);
      bq.push_back(r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      // Valid lowers land after the edge, so test them one edge later
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_awvalid || s_axi_wvalid);
      while (!s_axi_bvalid) @(posedge aclk);
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r = 2'h0);
      rq.push_back({r, d});
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid) @(posedge aclk);
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask : rd

   task automatic pl(input int n, input bit lo);
      repeat (n) begin
         @(posedge aclk);
         if (lo) low_osc_clk <= 1'b1;
         else ext_count_clock_pin <= 1'b1;
         @(posedge aclk);
         if (lo) low_osc_clk <= 1'b0;
         else ext_count_clock_pin <= 1'b0;
      end
      repeat (2) @(posedge aclk);
   endtask : pl

   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (s_axi_rvalid && s_axi_rready)
         chk("read", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
      if (s_axi_bvalid && s_axi_bready)
         chk("bresp", 34'(s_axi_bresp), 34'(bq.pop_front()));
      if (cycles == 30000) begin
         mismatches++;
         tally_and_finish();
      end
   end

   initial begin
      w = $urandom(32'h5F40);
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`EUT_OFF_CTRL, 32'h10);
      rd(`EUT_OFF_COUNT, 32'h0);
      rd(`EUT_OFF_STATUS, 32'h0);
      wr(8'h18, 32'hFF, `EUT_RESP_SLVERR);
      rd(8'h18, 32'h0, `EUT_RESP_SLVERR);
      repeat (4) begin
         w = $urandom;
         wr(`EUT_OFF_COUNT, w);
         rd(`EUT_OFF_COUNT, w & 32'hFF);
      end
      wr(`EUT_OFF_CTRL, 32'h12);
      wr(`EUT_OFF_COUNT, 32'h0);
      pl(4, 1'b0);
      rd(`EUT_OFF_COUNT, 32'h0);
      wr(`EUT_OFF_CTRL, 32'h13);
      pl(5, 1'b0);
      rd(`EUT_OFF_COUNT, 32'h5);
      wr(`EUT_OFF_CTRL, 32'h1B);
      pl(3, 1'b0);
      rd(`EUT_OFF_COUNT, 32'h8);
      // Low-speed source divided by eight, pin ignored
      wr(`EUT_OFF_CTRL, 32'h47);
      pl(16, 1'b1);
      pl(5, 1'b0);
      rd(`EUT_OFF_COUNT, 32'hA);
      wr(`EUT_OFF_CTRL, 32'h4F);
      pl(8, 1'b1);
      rd(`EUT_OFF_COUNT, 32'hB);
      // Each pass leaves a residue that the next pass's control write clears; the last pass's residue is read back from PSC
      for (int n = 0; n < 8; n++) begin
         wr(`EUT_OFF_CTRL, 32'((n << 5) | 3));
         wr(`EUT_OFF_COUNT, 32'h0);
         pl(3 * (2 << n) - 1, 1'b0);
         rd(`EUT_OFF_COUNT, 32'h2);
      end
      wr(`EUT_OFF_CTRL, 32'h13);
      rd(`EUT_OFF_PSC, 32'hFF);
      wr(`EUT_OFF_COUNT, 32'hFE);
      wr(`EUT_OFF_MASK, 32'h1);
      pl(2, 1'b0);
      chk("irq", 34'(irq), 34'h0);
      rd(`EUT_OFF_STATUS, 32'h1);
      rd(`EUT_OFF_COUNT, 32'h0);
      wr(`EUT_OFF_GLOBAL, 32'h1);
      chk("irq", 34'(irq), 34'h1);
      wr(`EUT_OFF_STATUS, 32'h1);
      chk("irq", 34'(irq), 34'h1);
      wr(`EUT_OFF_MASK, 32'h0);
      chk("irq", 34'(irq), 34'h0);
      wr(`EUT_OFF_MASK, 32'h1);
      chk("irq", 34'(irq), 34'h1);
      wr(`EUT_OFF_STATUS, 32'h0);
      chk("irq", 34'(irq), 34'h0);
      rd(`EUT_OFF_STATUS, 32'h0);
      pl(1, 1'b0);
      rd(`EUT_OFF_COUNT, 32'h1);
      s_axi_wstrb <= 4'hE;
      wr(`EUT_OFF_COUNT, 32'h55);
      s_axi_wstrb <= 4'hF;
      rd(`EUT_OFF_COUNT, 32'h1);
      // Instruction clock runs five edges between the two commits
      wr(`EUT_OFF_CTRL, 32'h14);
      wr(`EUT_OFF_COUNT, 32'hFF);
      wr(`EUT_OFF_CTRL, 32'h15);
      wr(`EUT_OFF_CTRL, 32'h14);
      rd(`EUT_OFF_STATUS, 32'h1);
      rd(`EUT_OFF_COUNT, 32'h4);
      tally_and_finish();
   end
endmodule : tb_top
